// File: logic/rtu_defs.svh
// Purpose: Constants for the RTU serial slave interpreter
// Assumes: 125 MHz system clock
// Notes: Baud figures in bits per second, counts derived in the module
`ifndef RTU_DEFS_SVH
`define RTU_DEFS_SVH
`define CLK_HZ 125000000
`define BAUD_0 4800
`define BAUD_1 9600
`define BAUD_2 19200
`define BAUD_3 38400
`define BAUD_4 57600
`define BAUD_5 115200
`define GAP_CHARS 4
`define MAX_WORDS 16
`define CMD_READ 8'h03
`define CMD_WR1 8'h06
`define CMD_WRN 8'h10
`define EXC_FLAG 8'h80
`define EXC_FUNC 8'h01
`define EXC_ADDR 8'h02
`define EXC_VALUE 8'h03
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`define FB_DEPTH 48
`define TB_DEPTH 37
`define LEN_SHORT 6'h08
`define LEN_WRN_HDR 6'h09
`define MIN_FRAME 6'h04
`endif

// File: logic/rtu_pkg.sv
// Purpose: Types shared by the RTU serial slave interpreter
// Assumes: Nothing beyond the constants header
// Notes: Settings and word-store requests travel as packed structs
package rtu_pkg;
    typedef struct packed {
        logic [7:0] station;
        logic [2:0] baud_sel;
        logic [2:0] char_fmt;
    } cfg_t;
    typedef struct packed {
        logic valid;
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } word_req_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;
    typedef enum logic [1:0] {ST_RX, ST_EXEC, ST_TX} main_state_t;
endpackage

// File: logic/rtu_serial_slave_interpreter.sv
// Purpose: RTU slave: frames, checks and executes word requests on RS485
// Assumes: CFG and word store are on CLK_SYS; store answers combinationally
// Notes: Bad check value or foreign station: frame dropped silently
`timescale 1ns/10ps
`include "rtu_defs.svh"
module rtu_serial_slave_interpreter
    import rtu_pkg::*;
#(
    parameter int CLK_FREQ_HZ = `CLK_HZ
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SRST,
    // Settings
    input wire cfg_t CFG,
    // RS485 line
    input wire logic RX_PIN,
    output logic TX_PIN,
    output logic TX_EN,
    // Word store
    output word_req_t WORD_REQ,
    input wire logic [15:0] WORD_RDATA,
    input wire logic WORD_ADDR_OK
);
    // Merge one byte into the check accumulator
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // Clock cycles per bit for a rate selection
    function automatic logic [19:0] baud_div(input logic [2:0] sel);
        case (sel)
            3'h0: baud_div = 20'(CLK_FREQ_HZ / `BAUD_0);
            3'h1: baud_div = 20'(CLK_FREQ_HZ / `BAUD_1);
            3'h3: baud_div = 20'(CLK_FREQ_HZ / `BAUD_3);
            3'h4: baud_div = 20'(CLK_FREQ_HZ / `BAUD_4);
            3'h5: baud_div = 20'(CLK_FREQ_HZ / `BAUD_5);
            default: baud_div = 20'(CLK_FREQ_HZ / `BAUD_2);
        endcase
    endfunction

    logic [1:0] rx_sync_reg;
    logic rx_s;
    logic [19:0] div;
    logic par_en, par_odd, stop2;
    logic [3:0] tx_nbits;
    logic [23:0] gap_lim;
    rx_state_t rxs_reg, rxs_next;
    logic [19:0] rcnt_reg, rcnt_next;
    logic [3:0] rbit_reg, rbit_next;
    logic [7:0] rsh_reg, rsh_next;
    logic rpar_reg, rpar_next, byte_v_reg, byte_v_next, byte_err_reg, byte_err_next;
    logic [23:0] gap_reg, gap_next;
    logic fend_reg, fend_next;
    main_state_t ms_reg, ms_next;
    logic [7:0] fb_reg [`FB_DEPTH];
    logic [7:0] fb_next [`FB_DEPTH];
    logic [7:0] tb_reg [`TB_DEPTH];
    logic [7:0] tb_next [`TB_DEPTH];
    logic [5:0] flen_reg, flen_next, tlen_reg, tlen_next, tidx_reg, tidx_next;
    logic fbad_reg, fbad_next;
    logic [15:0] crc_reg, crc_next, crc1_reg, crc1_next, crc2_reg, crc2_next;
    logic [4:0] widx_reg, widx_next, wcnt_reg, wcnt_next;
    word_req_t req_reg, req_next;
    logic [11:0] tsh_reg, tsh_next;
    logic [3:0] tbits_reg, tbits_next;
    logic [19:0] tcnt_reg, tcnt_next;
    logic de_reg, de_next;
    logic [7:0] cmd, exc, tx_byte;
    logic [15:0] cnt16;
    logic [5:0] wofs;
    logic frame_ok, go_tx, tx_load;

    // Line synchroniser, first stage read only by the second
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            rx_sync_reg <= 2'b11;
        end else begin
            rx_sync_reg <= {rx_sync_reg[0], RX_PIN};
        end
    end

    // Settings decode
    assign rx_s = rx_sync_reg[1];
    assign div = baud_div(CFG.baud_sel);
    assign par_en = (CFG.char_fmt == 3'h1) || (CFG.char_fmt == 3'h2) ||
                    (CFG.char_fmt == 3'h4) || (CFG.char_fmt == 3'h5);
    assign par_odd = (CFG.char_fmt == 3'h2) || (CFG.char_fmt == 3'h5);
    assign stop2 = (CFG.char_fmt >= 3'h3) && (CFG.char_fmt <= 3'h5);
    assign tx_nbits = 4'(10 + int'(par_en) + int'(stop2));
    assign gap_lim = 24'(`GAP_CHARS) * {20'h0_0000, tx_nbits} * {4'h0, div};

    // Receiver: character deframing and silence timer
    always_comb begin
        rxs_next = rxs_reg;
        rcnt_next = rcnt_reg;
        rbit_next = rbit_reg;
        rsh_next = rsh_reg;
        rpar_next = rpar_reg;
        byte_v_next = 1'b0;
        byte_err_next = byte_err_reg;
        gap_next = gap_reg;
        fend_next = 1'b0;
        case (rxs_reg)
            RX_IDLE: begin
                if (!rx_s && ms_reg == ST_RX) begin
                    rxs_next = RX_START;
                    rcnt_next = div >> 1;
                end
            end
            RX_START: begin
                if (rcnt_reg != 20'h0_0000) begin
                    rcnt_next = rcnt_reg - 20'h0_0001;
                end else if (rx_s) begin
                    rxs_next = RX_IDLE;
                end else begin
                    rxs_next = RX_BITS;
                    rcnt_next = div - 20'h0_0001;
                    rbit_next = 4'h0;
                    rpar_next = 1'b0;
                end
            end
            RX_BITS: begin
                if (rcnt_reg != 20'h0_0000) begin
                    rcnt_next = rcnt_reg - 20'h0_0001;
                end else begin
                    rcnt_next = div - 20'h0_0001;
                    rbit_next = rbit_reg + 4'h1;
                    if (rbit_reg < 4'h8) begin
                        rsh_next = {rx_s, rsh_reg[7:1]};
                        rpar_next = rpar_reg ^ rx_s;
                    end else if (rbit_reg == 4'h8 && par_en) begin
                        rpar_next = rpar_reg ^ rx_s;
                    end else begin
                        byte_v_next = 1'b1;
                        byte_err_next = !rx_s || (par_en && (rpar_reg != par_odd));
                        rxs_next = RX_IDLE;
                    end
                end
            end
            default: rxs_next = RX_IDLE;
        endcase
        if (rxs_reg != RX_IDLE || !rx_s || ms_reg != ST_RX) begin
            gap_next = 24'h00_0000;
        end else if (gap_reg < gap_lim) begin // No wrap if a format change shrinks the limit
            gap_next = gap_reg + 24'h00_0001;
            fend_next = (gap_reg + 24'h00_0001 == gap_lim);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            rxs_reg <= RX_IDLE;
            rcnt_reg <= 20'h0_0000;
            rbit_reg <= 4'h0;
            rsh_reg <= 8'h00;
            rpar_reg <= 1'b0;
            byte_v_reg <= 1'b0;
            byte_err_reg <= 1'b0;
            gap_reg <= 24'h00_0000;
            fend_reg <= 1'b0;
        end else begin
            rxs_reg <= rxs_next;
            rcnt_reg <= rcnt_next;
            rbit_reg <= rbit_next;
            rsh_reg <= rsh_next;
            rpar_reg <= rpar_next;
            byte_v_reg <= byte_v_next;
            byte_err_reg <= byte_err_next;
            gap_reg <= gap_next;
            fend_reg <= fend_next;
        end
    end

    // Request fields and frame acceptance
    assign cmd = fb_reg[1];
    assign cnt16 = {fb_reg[4], fb_reg[5]};
    assign wofs = {widx_reg, 1'b0};
    assign frame_ok = !fbad_reg && flen_reg >= `MIN_FRAME && fb_reg[0] == CFG.station &&
                      {fb_reg[flen_reg - 6'h01], fb_reg[flen_reg - 6'h02]} == crc2_reg;
    assign tx_byte = (tidx_reg < tlen_reg) ? tb_reg[tidx_reg] :
                     (tidx_reg == tlen_reg) ? crc_reg[7:0] : crc_reg[15:8];

    // Frame assembly, execution and reply transmission
    always_comb begin
        ms_next = ms_reg;
        fb_next = fb_reg;
        tb_next = tb_reg;
        flen_next = flen_reg;
        fbad_next = fbad_reg;
        crc_next = crc_reg;
        crc1_next = crc1_reg;
        crc2_next = crc2_reg;
        tlen_next = tlen_reg;
        tidx_next = tidx_reg;
        widx_next = widx_reg;
        wcnt_next = wcnt_reg;
        req_next = req_reg;
        tsh_next = tsh_reg;
        tbits_next = tbits_reg;
        tcnt_next = tcnt_reg;
        de_next = de_reg;
        exc = 8'h00;
        go_tx = 1'b0;
        tx_load = 1'b0;
        case (ms_reg)
            ST_RX: begin
                if (byte_v_reg) begin
                    if (byte_err_reg || flen_reg == 6'(`FB_DEPTH)) begin
                        fbad_next = 1'b1;
                    end else begin
                        fb_next[flen_reg] = rsh_reg;
                        flen_next = flen_reg + 6'h01;
                        crc2_next = crc1_reg;
                        crc1_next = crc_reg;
                        crc_next = crc_step(crc_reg, rsh_reg);
                    end
                end
                if (fend_reg) begin
                    flen_next = 6'h00;
                    fbad_next = 1'b0;
                    crc_next = `CRC_INIT;
                    if (frame_ok) begin
                        tb_next[0] = CFG.station;
                        tb_next[1] = cmd;
                        for (int k = 2; k < 6; k++) begin
                            tb_next[k] = fb_reg[k];
                        end
                        widx_next = 5'h00;
                        wcnt_next = cnt16[4:0];
                        req_next.valid = 1'b1;
                        req_next.we = (cmd != `CMD_READ);
                        req_next.addr = {fb_reg[2], fb_reg[3]};
                        req_next.wdata = (cmd == `CMD_WR1) ? cnt16 : {fb_reg[7], fb_reg[8]};
                        if (cmd == `CMD_READ) begin
                            if (flen_reg != `LEN_SHORT || cnt16 == 16'h0000 ||
                                cnt16 > 16'(`MAX_WORDS)) begin
                                exc = `EXC_VALUE;
                            end
                            tb_next[2] = {cnt16[6:0], 1'b0};
                            tlen_next = 6'(3 + 2 * cnt16[4:0]);
                        end else if (cmd == `CMD_WR1) begin
                            if (flen_reg != `LEN_SHORT) begin
                                exc = `EXC_VALUE;
                            end
                            wcnt_next = 5'h01;
                            tlen_next = 6'h06;
                        end else if (cmd == `CMD_WRN) begin
                            if (cnt16 < 16'h0002 || cnt16 > 16'(`MAX_WORDS) ||
                                fb_reg[6] != {cnt16[6:0], 1'b0} ||
                                flen_reg != `LEN_WRN_HDR + {cnt16[4:0], 1'b0}) begin
                                exc = `EXC_VALUE;
                            end
                            tlen_next = 6'h06;
                        end else begin
                            exc = `EXC_FUNC;
                        end
                        if (exc == 8'h00) begin
                            ms_next = ST_EXEC;
                        end
                    end
                end
            end
            ST_EXEC: begin
                if (!WORD_ADDR_OK) begin
                    exc = `EXC_ADDR;
                end else begin
                    if (!req_reg.we) begin
                        tb_next[6'h03 + wofs] = WORD_RDATA[15:8];
                        tb_next[6'h04 + wofs] = WORD_RDATA[7:0];
                    end
                    if (widx_reg + 5'h01 == wcnt_reg) begin
                        req_next.valid = 1'b0;
                        go_tx = 1'b1;
                    end else begin
                        widx_next = widx_reg + 5'h01;
                        req_next.addr = req_reg.addr + 16'h0001;
                        req_next.wdata = {fb_reg[6'h09 + wofs], fb_reg[6'h0A + wofs]};
                    end
                end
            end
            ST_TX: begin
                if (tbits_reg == 4'h0) begin
                    if (tidx_reg == tlen_reg + 6'h02) begin
                        de_next = 1'b0;
                        ms_next = ST_RX;
                    end else begin
                        tx_load = 1'b1;
                        tidx_next = tidx_reg + 6'h01;
                        tbits_next = tx_nbits;
                        tcnt_next = div - 20'h0_0001;
                        tsh_next = {2'b11, par_en ? (^tx_byte ^ par_odd) : 1'b1, tx_byte, 1'b0};
                        if (tidx_reg < tlen_reg) begin
                            crc_next = crc_step(crc_reg, tx_byte);
                        end
                    end
                end else if (tcnt_reg == 20'h0_0000) begin
                    tsh_next = {1'b1, tsh_reg[11:1]};
                    tbits_next = tbits_reg - 4'h1;
                    tcnt_next = div - 20'h0_0001;
                end else begin
                    tcnt_next = tcnt_reg - 20'h0_0001;
                end
            end
            default: ms_next = ST_RX;
        endcase
        if (exc != 8'h00) begin
            tb_next[1] = cmd | `EXC_FLAG;
            tb_next[2] = exc;
            tlen_next = 6'h03;
            req_next.valid = 1'b0;
            go_tx = 1'b1;
        end
        if (go_tx) begin
            ms_next = ST_TX;
            crc_next = `CRC_INIT;
            tidx_next = 6'h00;
            de_next = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        fb_reg <= fb_next;
        tb_reg <= tb_next;
        if (SRST) begin
            ms_reg <= ST_RX;
            flen_reg <= 6'h00;
            fbad_reg <= 1'b0;
            crc_reg <= `CRC_INIT;
            crc1_reg <= `CRC_INIT;
            crc2_reg <= `CRC_INIT;
            tlen_reg <= 6'h00;
            tidx_reg <= 6'h00;
            widx_reg <= 5'h00;
            wcnt_reg <= 5'h00;
            req_reg <= '0;
            tsh_reg <= 12'hFFF;
            tbits_reg <= 4'h0;
            tcnt_reg <= 20'h0_0000;
            de_reg <= 1'b0;
        end else begin
            ms_reg <= ms_next;
            flen_reg <= flen_next;
            fbad_reg <= fbad_next;
            crc_reg <= crc_next;
            crc1_reg <= crc1_next;
            crc2_reg <= crc2_next;
            tlen_reg <= tlen_next;
            tidx_reg <= tidx_next;
            widx_reg <= widx_next;
            wcnt_reg <= wcnt_next;
            req_reg <= req_next;
            tsh_reg <= tsh_next;
            tbits_reg <= tbits_next;
            tcnt_reg <= tcnt_next;
            de_reg <= de_next;
        end
    end

    // Outputs straight from flops
    assign TX_PIN = tsh_reg[0];
    assign TX_EN = de_reg;
    assign WORD_REQ = req_reg;

    // Checks on line, checksum and reply layout
    a_line_idle_high: assert property (@(posedge CLK_SYS) disable iff (SRST)
        !TX_EN |-> TX_PIN) else $error("line driven low while released");
    a_drive_tx_only: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (ms_reg == ST_TX && $past(ms_reg) == ST_TX) |-> TX_EN)
        else $error("transmitter off during reply");
    a_release_after: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (ms_reg == ST_TX ##1 ms_reg == ST_RX) |-> !TX_EN)
        else $error("transmitter held after reply");
    a_word_bound: assert property (@(posedge CLK_SYS) disable iff (SRST)
        WORD_REQ.valid |-> (widx_reg < wcnt_reg && wcnt_reg <= 5'h10))
        else $error("word access beyond count");
    a_crc_preset: assert property (@(posedge CLK_SYS) disable iff (SRST)
        fend_reg |=> crc_reg == `CRC_INIT) else $error("check not preset");
    a_foreign_quiet: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (fend_reg && fb_reg[0] != CFG.station) |=> ms_reg == ST_RX [*2])
        else $error("reacted to foreign station");
    a_read_bytes: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (ms_reg == ST_TX && tb_reg[1] == `CMD_READ) |->
        (tb_reg[2] == {2'b00, wcnt_reg, 1'b0} && tlen_reg == 6'h03 + tb_reg[2][5:0]))
        else $error("read reply byte count wrong");
    a_echo_len: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (ms_reg == ST_TX && (tb_reg[1] == `CMD_WRN || tb_reg[1] == `CMD_WR1)) |->
        (tlen_reg == 6'h06 && tb_reg[4] == fb_reg[4] && tb_reg[5] == fb_reg[5]))
        else $error("write echo wrong");
    a_err_flag: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (ms_reg == ST_TX && tlen_reg == 6'h03) |-> (tb_reg[1][7] && tb_reg[2] != 8'h00))
        else $error("error reply malformed");
    a_crc_low_first: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (tx_load && tidx_reg == tlen_reg) |-> ##1 (tsh_reg[8:1] == $past(crc_reg[7:0])))
        else $error("check low byte not first");
endmodule

// File: tb/rtu_master_model.sv
// Purpose: Bus master model on the far side of the RTU slave
// Assumes: Bit time in system clock cycles, format code 0 to 5
// Notes: Idle line stays high, as with a biased bus
`timescale 1ns/10ps
module rtu_master_model (
    // Clock and settings
    input wire logic clk,
    input wire logic [31:0] d_cyc,
    input wire logic [2:0] fmt,
    // Slave driver side
    input wire logic tx_pin,
    input wire logic tx_en,
    // Master driver
    output logic line_out
);
    logic [7:0] rx_q[$];
    int bad = 0;
    int en_cnt = 0;
    logic en_prev = 1'b0;
    logic [7:0] v;
    logic par;
    initial line_out = 1'b1;
    // One bit held for a full bit time
    task automatic put(input logic b);
        @(negedge clk);
        line_out = b;
        repeat (d_cyc - 1) @(negedge clk);
    endtask
    // Frame out, LSB first, parity and stop bits per format
    task automatic send(input logic [7:0] q[$]);
        foreach (q[i]) begin
            put(1'b0);
            for (int k = 0; k < 8; k++) put(q[i][k]);
            if (fmt % 3 != 0) put(^q[i] ^ (fmt % 3 == 2));
            put(1'b1);
            if (fmt >= 3) put(1'b1);
        end
    endtask
    // Enable span and line driven without enable
    always @(posedge clk) begin
        en_cnt = tx_en ? (en_prev ? en_cnt + 1 : 1) : en_cnt;
        if (tx_en === 1'b0 && tx_pin !== 1'b1) bad++;
        en_prev = tx_en;
    end
    // Reply receiver, checks parity and stop bits
    always begin
        @(posedge clk);
        if (tx_en === 1'b1 && tx_pin === 1'b0) begin
            repeat (d_cyc / 2) @(posedge clk);
            for (int k = 0; k < 8; k++) begin
                repeat (d_cyc) @(posedge clk);
                v[k] = tx_pin;
            end
            par = ^v ^ (fmt % 3 == 2);
            if (fmt % 3 != 0) begin
                repeat (d_cyc) @(posedge clk);
                if (tx_pin !== par) bad++;
            end
            repeat (d_cyc) @(posedge clk);
            if (tx_pin !== 1'b1) bad++;
            if (fmt >= 3) begin
                repeat (d_cyc) @(posedge clk);
                if (tx_pin !== 1'b1) bad++;
            end
            rx_q.push_back(v);
        end
    end
endmodule

// File: tb/test_rtu_serial_slave_interpreter.sv
// Purpose: Self-checking bench for the RTU slave interpreter
// Assumes: Shortened clock figure, so bit times are 5 to 120 cycles
// Notes: Rows in one loop, reset and silent cases after it
`timescale 1ns/10ps
module test_rtu_serial_slave_interpreter;
    import rtu_pkg::*;
    localparam int F = 576000;
    localparam int RATE[6] = '{4800, 9600, 19200, 38400, 57600, 115200};
    typedef struct packed {
        logic [7:0] sta;
        logic [2:0] fmt;
        logic [2:0] baud;
        logic [7:0] cmd;
        logic [15:0] addr;
        logic [15:0] cnt;
        logic [7:0] exc;
    } row_t;
    row_t rows[9];
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    cfg_t cfg = '{station: 8'h01, baud_sel: 3'h5, char_fmt: 3'h0};
    logic mline;
    wire logic rx_pin;
    wire logic tx_pin;
    wire logic tx_en;
    word_req_t word_req;
    logic [15:0] word_rdata;
    logic word_addr_ok;
    logic [31:0] d_cyc = 32'h0000_0005;
    logic [31:0] wlog[$];
    int err_total = 0;
    int comparisons = 0;
    always #4 clk_sys = ~clk_sys;
    // Word store: fixed pattern, addresses below 0100H accepted
    always_comb begin
        word_rdata = word_req.addr ^ 16'hA5C3;
        word_addr_ok = word_req.addr < 16'h0100;
    end
    // Log of committed store writes
    always @(posedge clk_sys) begin
        if (word_req.valid && word_req.we && word_addr_ok) begin
            wlog.push_back({word_req.addr, word_req.wdata});
        end
    end
    // Half-duplex bus level
    assign rx_pin = tx_en ? tx_pin : mline;
    rtu_serial_slave_interpreter #(.CLK_FREQ_HZ(F)) u_dut (.CLK_SYS(clk_sys), .SRST(srst),
        .CFG(cfg), .RX_PIN(rx_pin), .TX_PIN(tx_pin), .TX_EN(tx_en), .WORD_REQ(word_req),
        .WORD_RDATA(word_rdata), .WORD_ADDR_OK(word_addr_ok));
    rtu_master_model u_master (.clk(clk_sys), .d_cyc(d_cyc), .fmt(cfg.char_fmt),
        .tx_pin(tx_pin), .tx_en(tx_en), .line_out(mline));
    task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic chk_wr(input string what, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic chk_bit(input string what, input logic e, input logic s);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %b seen %b", what, e, s);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Check value: preset, byte merge, eight shift steps
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    // One request, expected reply and store writes
    task automatic run_row(input row_t r, input logic bad_crc, input logic abort);
        logic [7:0] q[$];
        logic [7:0] e[$];
        logic [31:0] w[$];
        logic [15:0] c;
        int ch, gap, n, t, span;
        @(negedge clk_sys);
        cfg.baud_sel = r.baud;
        cfg.char_fmt = r.fmt;
        d_cyc = 32'(F / RATE[r.baud]);
        ch = 10 + int'(r.fmt % 3 != 0) + int'(r.fmt >= 3);
        gap = 4 * ch * int'(d_cyc);
        repeat (gap + 20) @(negedge clk_sys);
        u_master.rx_q.delete();
        u_master.bad = 0;
        wlog.delete();
        n = (r.cmd == 8'h06) ? 1 : int'(r.cnt);
        q = '{r.sta, r.cmd, r.addr[15:8], r.addr[7:0]};
        if (r.cmd == 8'h06) q = {q, 8'h03, 8'hE8};
        else q = {q, r.cnt[15:8], r.cnt[7:0]};
        if (r.cmd == 8'h10) begin
            q.push_back(8'(2 * r.cnt));
            for (int i = 0; i < n; i++) q = {q, 8'h00, 8'(8'h64 + i)};
        end
        c = crc16(q);
        q = {q, c[7:0] ^ {7'h00, bad_crc}, c[15:8]};
        if (r.sta == cfg.station && !bad_crc) begin
            if (r.exc != 8'h00) e = '{cfg.station, r.cmd | 8'h80, r.exc};
            else if (r.cmd == 8'h03) begin
                e = '{cfg.station, 8'h03, 8'(2 * r.cnt)};
                for (int i = 0; i < n; i++) begin
                    c = 16'(r.addr + i) ^ 16'hA5C3;
                    e = {e, c[15:8], c[7:0]};
                end
            end else e = q[0:5];
            if (r.cmd != 8'h03 && (r.exc == 8'h00 || r.exc == 8'h02)) begin
                for (int i = 0; i < n; i++) begin
                    if (r.addr + i < 16'h0100) begin
                        w.push_back({16'(r.addr + i),
                            (r.cmd == 8'h06) ? 16'h03E8 : 16'(16'h0064 + i)});
                    end
                end
            end
            c = crc16(e);
            e = {e, c[7:0], c[15:8]};
        end
        u_master.send(q);
        t = 0;
        while (tx_en !== 1'b1 && t < gap + 40) begin
            @(negedge clk_sys);
            t++;
        end
        chk_bit("reply start", e.size() != 0, tx_en);
        if (e.size() != 0 && tx_en !== 1'b1) results();
        if (abort) begin
            repeat (50) @(negedge clk_sys);
            srst = 1'b1;
            repeat (2) @(negedge clk_sys);
            chk_bit("enable in reset", 1'b0, tx_en);
            chk_bit("line in reset", 1'b1, tx_pin);
            srst = 1'b0;
            return;
        end
        span = e.size() * ch * int'(d_cyc);
        t = 0;
        // Each character has one extra idle cycle before the next start bit
        while (tx_en !== 1'b0 && t < span + e.size() + 20) begin
            @(negedge clk_sys);
            t++;
        end
        if (tx_en !== 1'b0) begin
            err_total++;
            results();
        end
        repeat (2 * d_cyc) @(negedge clk_sys);
        chk_bit("reply length", 1'b1, u_master.rx_q.size() == e.size());
        foreach (e[i]) chk_byte("reply byte", e[i], u_master.rx_q[i]);
        if (e.size() != 0) begin
            chk_bit("enable span", 1'b1,
                u_master.en_cnt >= span && u_master.en_cnt <= span + e.size() + 1);
        end
        chk_bit("char errors", 1'b1, u_master.bad == 0);
        chk_bit("write count", 1'b1, wlog.size() == w.size());
        foreach (w[i]) chk_wr("store write", w[i], wlog[i]);
        $display("case cmd %h station %h done", r.cmd, r.sta);
    endtask
    initial begin
        rows = '{'{8'h01, 3'h0, 3'h5, 8'h03, 16'h0004, 16'h0002, 8'h00},
            '{8'h01, 3'h1, 3'h0, 8'h06, 16'h00A0, 16'h0001, 8'h00},
            '{8'h01, 3'h2, 3'h1, 8'h10, 16'h0010, 16'h0002, 8'h00},
            '{8'h01, 3'h3, 3'h5, 8'h03, 16'h0000, 16'h0010, 8'h00},
            '{8'h01, 3'h4, 3'h2, 8'h03, 16'h0000, 16'h0011, 8'h03},
            '{8'h01, 3'h5, 3'h3, 8'h05, 16'h0000, 16'h0001, 8'h01},
            '{8'h01, 3'h0, 3'h4, 8'h03, 16'h00FF, 16'h0002, 8'h02},
            '{8'h01, 3'h0, 3'h5, 8'h10, 16'h00FE, 16'h0003, 8'h02},
            '{8'h01, 3'h0, 3'h5, 8'h10, 16'h0000, 16'h0001, 8'h03}};
        repeat (3) @(negedge clk_sys);
        chk_bit("enable in reset", 1'b0, tx_en);
        chk_bit("line in reset", 1'b1, tx_pin);
        chk_bit("store in reset", 1'b0, word_req.valid);
        repeat (2) @(negedge clk_sys);
        srst = 1'b0;
        $display("reset test done");
        foreach (rows[i]) run_row(rows[i], 1'b0, 1'b0);
        run_row('{8'h02, 3'h0, 3'h5, 8'h03, 16'h0004, 16'h0001, 8'h00}, 1'b0, 1'b0);
        run_row(rows[0], 1'b1, 1'b0);
        cfg.station = 8'hFF;
        run_row('{8'hFF, 3'h0, 3'h5, 8'h03, 16'h0020, 16'h0001, 8'h00}, 1'b0, 1'b0);
        run_row('{8'hFF, 3'h3, 3'h5, 8'h03, 16'h0000, 16'h0010, 8'h00}, 1'b0, 1'b1);
        $display("reset in reply done");
        run_row('{8'hFF, 3'h0, 3'h5, 8'h03, 16'h0004, 16'h0002, 8'h00}, 1'b0, 1'b0);
        results();
    end
endmodule
